// ==== src/dpl_device.sv ====
/*
 * Device end: power modes, isolation link enable, PLL lock timer,
 * frame detect, and automatic / manual calibration sequencing.
 * Assumes the host drives the link signals synchronously to CORE_CLK
 * and that line-side inputs are synchronous as well.
 */
// Functional notes
// - Host asserts reset at every power-up
// - Reset defaults keep line side powered down
// - PLL locks within 1 ms of clock
// - Host init order ends writing 0x00
// - Link off while link powerdown set
// - Host waits lock before clearing link powerdown
// - Link carries data, control, ring, caller ID
// - Reset operation: link off, line status invalid
// - Both bits clear gives normal mode
// - Device powerdown alone: sleep, link and ring
// - Host keeps bit clock running in sleep
// - Host leaves sleep by reset and reprogram
// - Both bits set: complete powerdown, no ring
// - Host leaves deep powerdown likewise
// - Auto calibration on off-hook or power loss
// - 17 ms resistor calibration, skippable by bit
// - 256 ms converter calibration after settle
// - Manual calibration by trigger pulse, 256 ms
// - Host starts manual calibration 256 ms early
// - Frame detect within 10 ms of enable
`timescale 1ns/1ns
`default_nettype none
module dpl_device
    import dpl_pkg::*;
#(
    parameter logic [dpl_pkg::CNT_W-1:0] PLL_CYC = 22'(dpl_pkg::PLL_LOCK_CYC),
    parameter logic [dpl_pkg::CNT_W-1:0] LINK_CYC = 22'(dpl_pkg::LINK_EST_CYC),
    parameter logic [dpl_pkg::CNT_W-1:0] RES_CYC = 22'(dpl_pkg::RES_CAL_CYC),
    parameter logic [dpl_pkg::CNT_W-1:0] ADC_CYC = 22'(dpl_pkg::ADC_CAL_CYC)
)(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Host link
    dpl_if.dev IFC,
    // Line side
    input wire logic [7:0] LINE_RX_DATA,
    input wire logic LINE_RING,
    input wire logic LINE_POWER_OK,
    input wire logic LINE_DC_SETTLED,
    output logic [7:0] LINE_TX_DATA,
    output logic LINE_OFFHOOK,
    output logic LINK_ENABLE,
    output logic RES_CAL_ACTIVE,
    output logic ADC_CAL_ACTIVE
);
    import dpl_pkg::*;

    // ************************************************************
    // Registers and decode
    // ************************************************************
    logic [7:0] pwr_reg, offhook_reg, cal_reg, rcal_reg;
    logic [7:0] line_reg, fscale_reg, pcm_reg;
    logic [7:0] rd_next;
    logic [7:0] status_byte;
    logic dev_rst;
    logic link_pd, dev_pd, deep_pd, sleep_mode, low_power;
    logic wr_ok;

    // Host reset pin and core reset act alike
    assign dev_rst = RST || !IFC.reset_n;
    assign link_pd = pwr_reg[PWR_LINK_POWERDOWN];
    assign dev_pd = pwr_reg[PWR_DEVICE_POWERDOWN];
    assign deep_pd = link_pd && dev_pd;
    assign sleep_mode = !link_pd && dev_pd;
    assign low_power = dev_pd;
    // Only a reset can bring the device out of sleep or deep powerdown
    assign wr_ok = IFC.wr_en && !low_power;

    always_ff @(posedge CORE_CLK)
    begin
        if (dev_rst)
        begin
            pwr_reg <= PWR_RESET_VAL;
            offhook_reg <= REG_ZERO;
            cal_reg <= REG_ZERO;
            rcal_reg <= REG_ZERO;
            line_reg <= REG_ZERO;
            fscale_reg <= REG_ZERO;
            pcm_reg <= REG_ZERO;
        end
        else if (wr_ok)
        begin
            // Written value takes effect on the following cycle
            if (IFC.addr == DEV_PWR) pwr_reg <= IFC.wr_data;
            if (IFC.addr == DEV_OFFHOOK) offhook_reg <= IFC.wr_data;
            if (IFC.addr == DEV_CAL) cal_reg <= IFC.wr_data;
            if (IFC.addr == DEV_RCAL) rcal_reg <= IFC.wr_data;
            if (IFC.addr == DEV_LINE) line_reg <= IFC.wr_data;
            if (IFC.addr == DEV_FSCALE) fscale_reg <= IFC.wr_data;
            if (IFC.addr == DEV_PCM) pcm_reg <= IFC.wr_data;
        end
    end

    // ************************************************************
    // Bit clock activity and PLL lock
    // ************************************************************
    logic bclk_prev_reg;
    logic [2:0] idle_reg;
    logic [CNT_W-1:0] pll_cnt_reg;
    logic clk_running, pll_locked_next;

    assign clk_running = idle_reg < CLK_LOST_CYC;
    assign pll_locked_next = clk_running && pll_cnt_reg == PLL_CYC;

    always_ff @(posedge CORE_CLK)
    begin
        if (dev_rst)
        begin
            bclk_prev_reg <= 1'b0;
            idle_reg <= CLK_LOST_CYC;
            pll_cnt_reg <= '0;
        end
        else
        begin
            bclk_prev_reg <= IFC.bit_clock;
            if (IFC.bit_clock != bclk_prev_reg) idle_reg <= 3'h0;
            else if (clk_running) idle_reg <= idle_reg + 3'h1;
            // Lock timer restarts whenever the clock stops
            if (!clk_running) pll_cnt_reg <= '0;
            else if (pll_cnt_reg != PLL_CYC) pll_cnt_reg <= pll_cnt_reg + 22'h1;
        end
    end

    // ************************************************************
    // Isolation link and frame detect
    // ************************************************************
    logic link_on, fdt_next;
    logic [CNT_W-1:0] link_cnt_reg;

    // No data, ring or frame detect until link powerdown clears and clocks are good; register access is not gated
    assign link_on = !link_pd && pll_locked_next;
    assign fdt_next = link_on && link_cnt_reg == LINK_CYC;

    always_ff @(posedge CORE_CLK)
    begin
        if (dev_rst || !link_on)
            link_cnt_reg <= '0;
        else if (link_cnt_reg != LINK_CYC)
            link_cnt_reg <= link_cnt_reg + 22'h1;
    end

    // ************************************************************
    // Calibration sequencer
    // ************************************************************
    dpl_cal_t cal_state, cal_next;
    logic [CNT_W-1:0] cal_cnt_reg;
    logic offhook_on, offhook_prev_reg, pwr_ok_prev_reg, manual_cal_trigger_prev_reg;
    logic auto_go, manual_go, cal_abort, cal_cnt_clr;

    assign offhook_on = offhook_reg[OFFHOOK_BIT] && fdt_next && !low_power;
    assign auto_go = !cal_reg[CAL_AUTO_CAL_DISABLE] && offhook_on &&
        (!offhook_prev_reg || (pwr_ok_prev_reg && !LINE_POWER_OK));
    // Trigger taken on its fall, after the one-then-zero pulse
    assign manual_go = cal_reg[CAL_AUTO_CAL_DISABLE] && offhook_on &&
        manual_cal_trigger_prev_reg && !cal_reg[CAL_MANUAL_CAL_TRIGGER];
    assign cal_abort = !offhook_on;

    always_comb
    begin
        cal_next = cal_state;
        if (cal_abort)
            cal_next = C_IDLE;
        else if (auto_go)
            cal_next = rcal_reg[RCAL_RESISTOR_CAL_DISABLE] ? C_DC : C_RES;
        else if (manual_go)
            cal_next = C_ADC;
        else
        begin
            unique case (cal_state)
                C_IDLE: cal_next = C_IDLE;
                C_RES: if (cal_cnt_reg == RES_CYC) cal_next = C_DC;
                C_DC: if (LINE_DC_SETTLED) cal_next = C_ADC;
                C_ADC: if (cal_cnt_reg == ADC_CYC) cal_next = C_IDLE;
            endcase
        end
    end

    assign cal_cnt_clr = cal_next != cal_state || auto_go || manual_go;

    always_ff @(posedge CORE_CLK)
    begin
        if (dev_rst)
        begin
            cal_state <= C_IDLE;
            cal_cnt_reg <= '0;
            offhook_prev_reg <= 1'b0;
            pwr_ok_prev_reg <= 1'b0;
            manual_cal_trigger_prev_reg <= 1'b0;
        end
        else
        begin
            cal_state <= cal_next;
            cal_cnt_reg <= cal_cnt_clr ? '0 : cal_cnt_reg + 22'h1;
            offhook_prev_reg <= offhook_on;
            pwr_ok_prev_reg <= LINE_POWER_OK;
            manual_cal_trigger_prev_reg <= cal_reg[CAL_MANUAL_CAL_TRIGGER];
        end
    end

    // ************************************************************
    // Read mux and outputs
    // ************************************************************
    assign status_byte = {1'b0, fdt_next, 4'h0, cal_next != C_IDLE, pll_locked_next};

    always_comb
    begin
        unique case (IFC.addr)
            DEV_PWR: rd_next = pwr_reg;
            DEV_OFFHOOK: rd_next = offhook_reg;
            DEV_STATUS: rd_next = status_byte;
            DEV_CAL: rd_next = cal_reg;
            DEV_RCAL: rd_next = rcal_reg;
            DEV_LINE: rd_next = line_reg;
            DEV_FSCALE: rd_next = fscale_reg;
            DEV_PCM: rd_next = pcm_reg;
            default: rd_next = REG_ZERO;
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (dev_rst)
        begin
            IFC.rd_data <= REG_ZERO;
            IFC.rx_data <= REG_ZERO;
            IFC.pll_locked <= 1'b0;
            IFC.link_frame_detected <= 1'b0;
            IFC.ring_detect_output <= 1'b0;
            IFC.cal_busy <= 1'b0;
            LINE_TX_DATA <= REG_ZERO;
            LINE_OFFHOOK <= 1'b0;
            LINK_ENABLE <= 1'b0;
            RES_CAL_ACTIVE <= 1'b0;
            ADC_CAL_ACTIVE <= 1'b0;
        end
        else
        begin
            IFC.rd_data <= rd_next;
            // Voice and caller ID traffic share the rx stream; sleep stops it
            IFC.rx_data <= (fdt_next && !low_power) ? LINE_RX_DATA : REG_ZERO;
            LINE_TX_DATA <= (fdt_next && !low_power) ? IFC.tx_data : REG_ZERO;
            IFC.pll_locked <= pll_locked_next;
            IFC.link_frame_detected <= fdt_next;
            // Ring stays alive in sleep; deep powerdown has no link
            IFC.ring_detect_output <= fdt_next && !deep_pd && LINE_RING;
            IFC.cal_busy <= cal_next != C_IDLE;
            LINE_OFFHOOK <= offhook_on;
            LINK_ENABLE <= link_on;
            RES_CAL_ACTIVE <= cal_next == C_RES;
            ADC_CAL_ACTIVE <= cal_next == C_ADC;
        end
    end

endmodule
`default_nettype wire

// ==== src/dpl_pkg.sv ====
/*
 * Shared constants for the line-link power and calibration sequencer:
 * device register map, bit positions, reset values, timing figures,
 * host-side bus register map.
 * Assumes a single 10 MHz core clock on both ends.
 */
package dpl_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int CNT_W = 22;
    localparam int PLL_LOCK_MS = 1;
    localparam int PLL_LOCK_CYC = PLL_LOCK_MS * CYC_PER_MS - 2;
    localparam int LINK_EST_MS = 10;
    // Longest time: strictly under the figure
    localparam int LINK_EST_CYC = LINK_EST_MS * CYC_PER_MS - 2;
    localparam int RES_CAL_MS = 17;
    localparam int RES_CAL_CYC = RES_CAL_MS * CYC_PER_MS;
    localparam int ADC_CAL_MS = 256;
    localparam int ADC_CAL_CYC = ADC_CAL_MS * CYC_PER_MS;
    localparam logic [2:0] CLK_LOST_CYC = 3'h4;
    localparam logic [3:0] RST_HOLD_CYC = 4'h4;
    localparam logic [3:0] FRAME_SYNC_INPUT_DIV = 4'hf;

    // ************************************************************
    // Device register map
    // ************************************************************
    localparam logic [7:0] DEV_OFFHOOK = 8'h05;
    localparam logic [7:0] DEV_PWR = 8'h06;
    localparam logic [7:0] DEV_STATUS = 8'h0c;
    localparam logic [7:0] DEV_CAL = 8'h11;
    localparam logic [7:0] DEV_RCAL = 8'h19;
    localparam logic [7:0] DEV_LINE = 8'h1a;
    localparam logic [7:0] DEV_FSCALE = 8'h1e;
    localparam logic [7:0] DEV_PCM = 8'h21;
    localparam int PWR_LINK_POWERDOWN = 4;
    localparam int PWR_DEVICE_POWERDOWN = 3;
    localparam int OFFHOOK_BIT = 0;
    localparam int CAL_AUTO_CAL_DISABLE = 4;
    localparam int CAL_MANUAL_CAL_TRIGGER = 5;
    localparam int RCAL_RESISTOR_CAL_DISABLE = 5;
    localparam int STAT_PLL_LOCKED = 0;
    localparam int STAT_CAL_BUSY = 1;
    localparam int STAT_FRAME_DETECTED = 6;
    localparam logic [7:0] PWR_RESET_VAL = 8'h10;
    localparam logic [7:0] PWR_POWER_UP = 8'h00;
    localparam logic [7:0] REG_ZERO = 8'h00;

    // ************************************************************
    // Host bus register map (byte addresses)
    // ************************************************************
    localparam logic [4:0] HR_CTRL = 5'h00;
    localparam logic [4:0] HR_CFG = 5'h04;
    localparam logic [4:0] HR_DEVWR = 5'h08;
    localparam logic [4:0] HR_STATUS = 5'h0c;
    localparam logic [4:0] HR_TXD = 5'h10;
    localparam int CTRL_INIT = 0;
    localparam int CTRL_MANUAL_CAL_TRIGGER = 1;
    localparam int CTRL_CLK_RUN = 2;
    localparam int ST_BUSY = 8;
    localparam int ST_SLEEP = 9;

    typedef enum {C_IDLE, C_RES, C_DC, C_ADC} dpl_cal_t;
    typedef enum {H_IDLE, H_RST, H_LOCK, H_W33, H_W26, H_W30, H_W6,
                  H_CAL0, H_CAL1, H_CAL2, H_DW} dpl_host_t;

endpackage

// ==== src/dpl_if.sv ====
/*
 * Link between the host controller and the sequencer device.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface dpl_if;
    logic reset_n;
    logic bit_clock;
    logic frame_sync_input;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] tx_data;
    logic [7:0] rd_data;
    logic [7:0] rx_data;
    logic pll_locked;
    logic link_frame_detected;
    logic ring_detect_output;
    logic cal_busy;

    modport dev (
        input reset_n, bit_clock, frame_sync_input, wr_en, addr, wr_data, tx_data,
        output rd_data, rx_data, pll_locked, link_frame_detected,
        ring_detect_output, cal_busy
    );
    modport host (
        output reset_n, bit_clock, frame_sync_input, wr_en, addr, wr_data, tx_data,
        input rd_data, rx_data, pll_locked, link_frame_detected,
        ring_detect_output, cal_busy
    );
endinterface
`default_nettype wire

// ==== src/dpl_host.sv ====
/*
 * Host end: AHB-Lite slave with command registers, bit clock and frame
 * sync generation, reset pulsing and the start-up / calibration order.
 * Assumes a single AHB-Lite master issuing single word transfers.
 */
`timescale 1ns/1ns
`default_nettype none
module dpl_host
    import dpl_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    // Device link
    dpl_if.host IFC
);
    import dpl_pkg::*;

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic ahb_go, wr_ph_reg;
    logic [4:0] wa_reg;
    logic [31:0] rd_mux;
    logic [23:0] cfg_reg;
    logic [15:0] devwr_reg;
    logic [7:0] txd_reg;
    logic clk_run_reg, sleep_reg;
    logic init_req_reg, manual_cal_trigger_req_reg, dw_req_reg;
    logic wr_ctrl, wr_dw;
    dpl_host_t st, st_next;

    assign ahb_go = HSEL && HTRANS[1] && HREADY;
    assign wr_ctrl = wr_ph_reg && wa_reg == HR_CTRL;
    assign wr_dw = wr_ph_reg && wa_reg == HR_DEVWR;

    always_comb
    begin
        unique case (HADDR[4:0])
            HR_CTRL: rd_mux = {29'h0, clk_run_reg, 2'h0};
            HR_CFG: rd_mux = {8'h0, cfg_reg};
            HR_DEVWR: rd_mux = {16'h0, devwr_reg};
            HR_STATUS: rd_mux = {16'h0, 6'h0, sleep_reg, st != H_IDLE, IFC.rd_data};
            HR_TXD: rd_mux = {24'h0, IFC.rx_data};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            wr_ph_reg <= 1'b0;
            wa_reg <= 5'h0;
            HRDATA <= 32'h0;
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
            cfg_reg <= 24'h0;
            devwr_reg <= 16'h0;
            txd_reg <= 8'h0;
            clk_run_reg <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            wr_ph_reg <= ahb_go && HWRITE;
            wa_reg <= HADDR[4:0];
            HRDATA <= (ahb_go && !HWRITE) ? rd_mux : 32'h0;
            if (wr_ctrl) clk_run_reg <= HWDATA[CTRL_CLK_RUN];
            if (wr_ph_reg && wa_reg == HR_CFG) cfg_reg <= HWDATA[23:0];
            if (wr_dw) devwr_reg <= HWDATA[15:0];
            if (wr_ph_reg && wa_reg == HR_TXD) txd_reg <= HWDATA[7:0];
        end
    end

    // Pending commands; a new request wins over the clear by the sequencer
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            init_req_reg <= 1'b0;
            manual_cal_trigger_req_reg <= 1'b0;
            dw_req_reg <= 1'b0;
        end
        else
        begin
            init_req_reg <= (wr_ctrl && HWDATA[CTRL_INIT]) || (init_req_reg && st_next != H_RST);
            manual_cal_trigger_req_reg <= (wr_ctrl && HWDATA[CTRL_MANUAL_CAL_TRIGGER]) || (manual_cal_trigger_req_reg && st_next != H_CAL0);
            dw_req_reg <= wr_dw || (dw_req_reg && st_next != H_DW);
        end
    end

    // ************************************************************
    // Start-up and calibration sequencer
    // ************************************************************
    logic [3:0] hold_reg;
    logic [7:0] wa_next, wd_next;
    logic wr_next;

    always_comb
    begin
        st_next = st;
        unique case (st)
            H_IDLE:
                if (init_req_reg) st_next = H_RST;
                else if (manual_cal_trigger_req_reg) st_next = H_CAL0;
                else if (dw_req_reg) st_next = H_DW;
            H_RST: if (hold_reg == RST_HOLD_CYC) st_next = H_LOCK;
            H_LOCK: if (IFC.pll_locked) st_next = H_W33;
            H_W33: st_next = H_W26;
            H_W26: st_next = H_W30;
            H_W30: st_next = H_W6;
            H_W6: st_next = H_IDLE;
            H_CAL0: st_next = H_CAL1;
            H_CAL1: st_next = H_CAL2;
            H_CAL2: st_next = H_IDLE;
            H_DW: st_next = H_IDLE;
        endcase
    end

    // Software times the manual run about 256 ms ahead of traffic
    always_comb
    begin
        wr_next = 1'b1;
        wa_next = DEV_CAL;
        wd_next = REG_ZERO;
        unique case (st_next)
            H_W33: {wa_next, wd_next} = {DEV_PCM, cfg_reg[7:0]};
            H_W26: {wa_next, wd_next} = {DEV_LINE, cfg_reg[15:8]};
            H_W30: {wa_next, wd_next} = {DEV_FSCALE, cfg_reg[23:16]};
            H_W6: {wa_next, wd_next} = {DEV_PWR, PWR_POWER_UP};
            H_CAL0, H_CAL2: wd_next[CAL_AUTO_CAL_DISABLE] = 1'b1;
            H_CAL1:
            begin
                wd_next[CAL_AUTO_CAL_DISABLE] = 1'b1;
                wd_next[CAL_MANUAL_CAL_TRIGGER] = 1'b1;
            end
            H_DW: {wa_next, wd_next} = devwr_reg;
            default: wr_next = 1'b0;
        endcase
    end

    // ************************************************************
    // Link drive, bit clock and frame sync
    // ************************************************************
    logic [3:0] fs_cnt_reg;
    logic clk_on;

    // Clock is forced on while the device sleeps
    assign clk_on = clk_run_reg || sleep_reg || (st != H_IDLE && st != H_RST);

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            st <= H_IDLE;
            hold_reg <= 4'h0;
            sleep_reg <= 1'b0;
            fs_cnt_reg <= 4'h0;
            IFC.reset_n <= 1'b0;
            IFC.bit_clock <= 1'b0;
            IFC.frame_sync_input <= 1'b0;
            IFC.wr_en <= 1'b0;
            IFC.addr <= REG_ZERO;
            IFC.wr_data <= REG_ZERO;
            IFC.tx_data <= REG_ZERO;
        end
        else
        begin
            st <= st_next;
            hold_reg <= (st == H_RST) ? hold_reg + 4'h1 : 4'h0;
            if (st_next == H_RST) sleep_reg <= 1'b0;
            else if (wr_next && wa_next == DEV_PWR)
                sleep_reg <= wd_next[PWR_DEVICE_POWERDOWN];
            IFC.reset_n <= st_next != H_RST;
            IFC.bit_clock <= clk_on && !IFC.bit_clock;
            fs_cnt_reg <= clk_on ? fs_cnt_reg + 4'h1 : 4'h0;
            IFC.frame_sync_input <= clk_on && fs_cnt_reg == FRAME_SYNC_INPUT_DIV;
            IFC.wr_en <= wr_next;
            IFC.addr <= wr_next ? wa_next : IFC.addr;
            IFC.wr_data <= wd_next;
            IFC.tx_data <= txd_reg;
        end
    end

endmodule
`default_nettype wire

// ==== tb/dpl_asserts.sv ====
/* Checker on the host-device link signals.
   Assumes one core clock, synchronous active-high reset, short counts. */
`timescale 1ns/1ns
`default_nettype none
module dpl_asserts
    import dpl_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Link
    input wire logic reset_n,
    input wire logic bit_clock,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic pll_locked,
    input wire logic link_frame_detected,
    input wire logic ring_detect_output,
    input wire logic cal_busy
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // ************
    // Properties
    // ************
    logic [7:0] tog_reg;
    wire pwr_wr = wr_en && addr == DEV_PWR;
    // Wraps harmlessly: a wrapped count only weakens the check briefly
    always_ff @(posedge CORE_CLK)
        tog_reg <= (RST || !reset_n || bit_clock == $past(bit_clock)) ? 8'h00 : tog_reg + 8'h01;
    property p_lock; tog_reg > 8'h1e |-> pll_locked; endproperty
    a_lock: assert property (p_lock) else $error("no lock after clocking");
    property p_rst; $rose(reset_n) |-> (!link_frame_detected && !cal_busy) [*8]; endproperty
    a_rst: assert property (p_rst) else $error("line status after reset");
    property p_pdl; pwr_wr && wr_data[4] |-> ##[1:3] !link_frame_detected; endproperty
    a_pdl: assert property (p_pdl) else $error("link up while powered down");
    property p_fdt; pwr_wr && wr_data == 8'h00 && pll_locked |-> ##[1:45] link_frame_detected;
    endproperty
    a_fdt: assert property (p_fdt) else $error("frame detect late");
    property p_sleep; pwr_wr && wr_data == 8'h08 |-> ##3 link_frame_detected [*8]; endproperty
    a_sleep: assert property (p_sleep) else $error("link lost in sleep");
    property p_deep; pwr_wr && wr_data == 8'h18 |-> ##3 !ring_detect_output [*8]; endproperty
    a_deep: assert property (p_deep) else $error("ring in deep powerdown");
    property p_rdback; pwr_wr ##1 addr == DEV_PWR |-> ##1 rd_data == $past(wr_data, 2);
    endproperty
    a_rdback: assert property (p_rdback) else $error("power bits readback");
    property p_callen; $rose(cal_busy) |-> ##[50:200] !cal_busy; endproperty
    a_callen: assert property (p_callen) else $error("calibration length");
    property p_auto; wr_en && addr == DEV_OFFHOOK && wr_data[0] && link_frame_detected
        && !cal_busy |-> ##[1:4] cal_busy; endproperty
    a_auto: assert property (p_auto) else $error("no auto calibration");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/* Self-checking bench: host end and device end joined by the link.
   Assumes zero-wait bus slave and shortened device counts. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dpl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] line_rx = 8'h00;
    logic line_ring = 1'b0;
    logic hsel = 1'b1, pwr_ok = 1'b1, dc_ok = 1'b1;
    logic hready, hresp, link_en, res_act, adc_act, seen_res, seen_adc, line_oh;
    logic [31:0] hrdata, rd;
    logic [31:0] lfsr_reg = 32'hc277;
    logic [7:0] line_tx;
    logic [7:0] tx_q[$];
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    dpl_if u_dpl_if ();
    dpl_host u_dpl_host (.CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .IFC(u_dpl_if));
    dpl_device #(.PLL_CYC(22'h14), .LINK_CYC(22'h1e), .RES_CYC(22'h28), .ADC_CYC(22'h3c))
    u_dpl_device (.CORE_CLK(clk), .RST(rst), .IFC(u_dpl_if), .LINE_RX_DATA(line_rx),
        .LINE_RING(line_ring), .LINE_POWER_OK(pwr_ok), .LINE_DC_SETTLED(dc_ok),
        .LINE_TX_DATA(line_tx), .LINE_OFFHOOK(line_oh), .LINK_ENABLE(link_en),
        .RES_CAL_ACTIVE(res_act), .ADC_CAL_ACTIVE(adc_act));
    dpl_asserts u_dpl_asserts (.CORE_CLK(clk), .RST(rst), .reset_n(u_dpl_if.reset_n),
        .bit_clock(u_dpl_if.bit_clock), .wr_en(u_dpl_if.wr_en), .addr(u_dpl_if.addr),
        .wr_data(u_dpl_if.wr_data), .rd_data(u_dpl_if.rd_data),
        .pll_locked(u_dpl_if.pll_locked), .link_frame_detected(u_dpl_if.link_frame_detected),
        .ring_detect_output(u_dpl_if.ring_detect_output), .cal_busy(u_dpl_if.cal_busy));
    // ************
    // Tasks
    // ************
    always #50 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic idle();
        do ahb(1'b0, HR_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
    endtask
    task automatic devwr(input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, HR_DEVWR, {16'h0, a, d});
        idle();
    endtask
    task automatic init();
        ahb(1'b1, HR_CTRL, 32'h5);
        idle();
        while (u_dpl_if.link_frame_detected !== 1'b1) @(posedge clk);
    endtask
    task automatic calwatch();
        seen_res = 1'b0;
        seen_adc = 1'b0;
        repeat (300)
        begin
            @(posedge clk);
            seen_res |= res_act;
            seen_adc |= adc_act;
        end
    endtask
    // Hang guard: whole run is under two thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    // ************
    // Scenarios
    // ************
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        ahb(1'b0, HR_STATUS, 32'h0);
        chk("status", rd, 32'h0);
        chk("link", link_en, 32'h0);
        init();
        chk("link", link_en, 32'h1);
        repeat (4)
        begin
            lfsr_reg = lfsr(lfsr_reg);
            tx_q.push_back(lfsr_reg[7:0]);
            line_rx <= lfsr_reg[15:8];
            ahb(1'b1, HR_TXD, {24'h0, lfsr_reg[7:0]});
            hsel <= 1'b0;
            ahb(1'b1, HR_TXD, 32'h0);
            hsel <= 1'b1;
            repeat (3) @(posedge clk);
            chk("line tx", line_tx, tx_q.pop_front());
            ahb(1'b0, HR_TXD, 32'h0);
            chk("rx", rd, {24'h0, lfsr_reg[15:8]});
        end
        line_ring <= 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            devwr(DEV_RCAL, p[0] ? 8'h20 : 8'h00);
            dc_ok <= 1'b0;
            devwr(DEV_OFFHOOK, 8'h01);
            chk("dc wait", adc_act, 32'h0);
            dc_ok <= 1'b1;
            calwatch();
            chk("res cal", seen_res, !p[0]);
            chk("adc cal", seen_adc, 32'h1);
            chk("cal busy", u_dpl_if.cal_busy, 32'h0);
            chk("offhook", line_oh, 32'h1);
            if (p == 0)
                devwr(DEV_OFFHOOK, 8'h00);
        end
        pwr_ok <= 1'b0;
        calwatch();
        chk("power cal", seen_adc, 32'h1);
        ahb(1'b1, HR_CTRL, 32'h6);
        calwatch();
        chk("manual res", seen_res, 32'h0);
        chk("manual adc", seen_adc, 32'h1);
        devwr(DEV_PWR, 8'h08);
        repeat (3) @(posedge clk);
        chk("sleep ring", u_dpl_if.ring_detect_output, 32'h1);
        chk("sleep link", link_en, 32'h1);
        init();
        devwr(DEV_PWR, 8'h18);
        repeat (3) @(posedge clk);
        chk("deep ring", u_dpl_if.ring_detect_output, 32'h0);
        chk("deep link", link_en, 32'h0);
        results();
    end
endmodule
`default_nettype wire
